/* File: rtl/baud_consts.svh */
// offsets, field positions, reset values and counts of the baud generator
// assumes inclusion by bare name from the design files
`ifndef BAUD_CONSTS_SVH
`define BAUD_CONSTS_SVH

`define OFS_BAUD_CONTROL   8'h00
`define OFS_DIVISOR_LOW    8'h01
`define OFS_DIVISOR_HIGH   8'h02
`define OFS_TX_CONTROL     8'h03
`define OFS_WAKE_STATUS    8'h04

`define BIT_OVERFLOW       7
`define BIT_RX_IDLE        6
`define BIT_POLARITY       4
`define BIT_WIDE           3
`define BIT_WAKE_EN        1
`define BIT_AUTO_EN        0
`define BIT_SYNC_MODE      4
`define BIT_FAST_RATE      2
`define BIT_PENDING        0

`define RST_BAUD_CONTROL   8'h40
`define RST_DIVISOR        8'h00
`define RST_TX_CONTROL     8'h00

`define MULT_SLOW_NARROW   7'h40
`define MULT_MID           7'h10
`define MULT_FAST          7'h04
`define FRAME_BITS_DEF     10

`endif

/* File: rtl/baud_pkg.sv */
// types shared by the baud generator files
// assumes nothing beyond a sv compiler
package baud_pkg;
  typedef enum logic [3:0] {
    st_idle      = 4'b0001,
    st_busy      = 4'b0010,
    st_wake_fall = 4'b0100,
    st_wake_rise = 4'b1000
  } rx_state_t;
endpackage

/* File: rtl/baud_timer.sv */
// free running reload timer, 8 or 16 bits wide
// assumes clear_in and divisor_in come from logic on clk_in
`timescale 1ns/1ps
`default_nettype none
module baud_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             clear_in,
  input  wire logic             wide_in,
  input  wire logic [WIDTH-1:0] divisor_in,
  output logic                  wrap_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] limit;
  logic             next_wrap;

  if (WIDTH != 16) begin : g_check
    $error("baud_timer serves only a 16-bit width");
  end

  always_comb begin
    // narrow mode ignores the high divisor byte
    limit = wide_in ? divisor_in : {8'h00, divisor_in[7:0]};
    next_wrap = 1'b0;
    if (clear_in) begin
      next_count = '0;
    end else if (count >= limit) begin
      next_count = '0;
      next_wrap = 1'b1;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count    <= '0;
      wrap_out <= 1'b0;
    end else begin
      count    <= next_count;
      wrap_out <= next_wrap;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/baud_rate_generator.sv */
// baud rate generator with its control registers and line watcher
// assumes a register master on clk_in and an asynchronous rx line
//
// What this block does
// - one rate timer, 8 or 16 bits, paces async and sync operation
// - timer is 8-bit after reset; wide select makes it 16-bit
// - timer runs continuously, counting up from zero to the divisor byte pair when wide, to the low byte alone when narrow
// - async multiplier chosen by fast-rate and wide-timer selects together
// - sync mode ignores the fast-rate select
// - writing either divisor byte clears the timer at once
// - bit rate is clock over 64, 16 or 4 times divisor plus one
`timescale 1ns/1ps
`default_nettype none
`include "baud_consts.svh"
module baud_rate_generator #(
  parameter int FRAME_BITS = `FRAME_BITS_DEF
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       write_in,
  input  wire logic       read_in,
  output logic      [7:0] rdata_out,
  input  wire logic       tx_data_in,
  input  wire logic       rx_pin_in,
  output logic            tx_pin_out,
  output logic            bit_tick_out,
  output logic            receive_pending_out
);
  import baud_pkg::*;

  if (FRAME_BITS < 2 || FRAME_BITS > 16) begin : g_check
    $error("FRAME_BITS must lie between 2 and 16");
  end

  localparam logic [3:0] LAST_BIT = 4'(FRAME_BITS - 1);

  // multiplier of the timer period per bit
  function automatic logic [6:0] rate_mult(input logic sync, wide, fast);
    if (sync) begin
      rate_mult = `MULT_FAST;
    end else if (!wide && !fast) begin
      rate_mult = `MULT_SLOW_NARROW;
    end else if (wide && fast) begin
      rate_mult = `MULT_FAST;
    end else begin
      rate_mult = `MULT_MID;
    end
  endfunction

  // register state
  logic       polarity, wide_sel, wake_en, auto_en, sync_mode, fast_sel;
  logic       next_polarity, next_wide_sel, next_wake_en, next_auto_en;
  logic       next_sync_mode, next_fast_sel, pending, next_pending;
  logic [7:0] div_low, div_high, next_div_low, next_div_high;
  logic [7:0] rdata, next_rdata;
  logic       div_write;

  // rate state
  logic       timer_wrap, next_bit_tick, pin, next_pin;
  logic [5:0] mult_cnt, next_mult_cnt;

  // line state
  logic       rx_s1, rx_s2, rx_s3, rx_level, rx_prev, next_rx_level;
  logic       fall, rise, wake_done;
  rx_state_t  state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;

  assign div_write = write_in && (addr_in == `OFS_DIVISOR_LOW ||
                                  addr_in == `OFS_DIVISOR_HIGH);

  baud_timer #(
    .WIDTH (16)
  ) u_timer (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .clear_in   (div_write),
    .wide_in    (wide_sel),
    .divisor_in ({div_high, div_low}),
    .wrap_out   (timer_wrap)
  );

  always_comb begin
    next_polarity  = polarity;
    next_wide_sel  = wide_sel;
    next_wake_en   = wake_en;
    next_auto_en   = auto_en;
    next_sync_mode = sync_mode;
    next_fast_sel  = fast_sel;
    next_div_low   = div_low;
    next_div_high  = div_high;
    next_pending   = pending;
    next_rdata     = 8'h00;
    if (wake_done) begin
      next_wake_en = 1'b0;
    end
    if (write_in) begin
      if (addr_in == `OFS_BAUD_CONTROL) begin
        next_polarity = wdata_in[`BIT_POLARITY];
        next_wide_sel = wdata_in[`BIT_WIDE];
        next_wake_en  = wdata_in[`BIT_WAKE_EN];
        next_auto_en  = wdata_in[`BIT_AUTO_EN];
      end else if (addr_in == `OFS_DIVISOR_LOW) begin
        next_div_low = wdata_in;
      end else if (addr_in == `OFS_DIVISOR_HIGH) begin
        next_div_high = wdata_in;
      end else if (addr_in == `OFS_TX_CONTROL) begin
        next_sync_mode = wdata_in[`BIT_SYNC_MODE];
        next_fast_sel  = wdata_in[`BIT_FAST_RATE];
      end else if (addr_in == `OFS_WAKE_STATUS) begin
        if (wdata_in[`BIT_PENDING]) begin
          next_pending = 1'b0;
        end
      end
    end
    // a wake event in the clearing cycle still lands
    if (wake_done) begin
      next_pending = 1'b1;
    end
    if (read_in) begin
      if (addr_in == `OFS_BAUD_CONTROL) begin
        next_rdata[`BIT_RX_IDLE]  = (state != st_busy);
        next_rdata[`BIT_POLARITY] = polarity;
        next_rdata[`BIT_WIDE]     = wide_sel;
        next_rdata[`BIT_WAKE_EN]  = wake_en;
        next_rdata[`BIT_AUTO_EN]  = auto_en;
      end else if (addr_in == `OFS_DIVISOR_LOW) begin
        next_rdata = div_low;
      end else if (addr_in == `OFS_DIVISOR_HIGH) begin
        next_rdata = div_high;
      end else if (addr_in == `OFS_TX_CONTROL) begin
        next_rdata[`BIT_SYNC_MODE] = sync_mode;
        next_rdata[`BIT_FAST_RATE] = fast_sel;
      end else if (addr_in == `OFS_WAKE_STATUS) begin
        next_rdata[`BIT_PENDING] = pending;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      polarity  <= 1'(`RST_BAUD_CONTROL >> `BIT_POLARITY);
      wide_sel  <= 1'b0;
      wake_en   <= 1'b0;
      auto_en   <= 1'b0;
      sync_mode <= 1'b0;
      fast_sel  <= 1'b0;
      div_low   <= `RST_DIVISOR;
      div_high  <= `RST_DIVISOR;
      pending   <= 1'b0;
      rdata     <= 8'h00;
    end else begin
      polarity  <= next_polarity;
      wide_sel  <= next_wide_sel;
      wake_en   <= next_wake_en;
      auto_en   <= next_auto_en;
      sync_mode <= next_sync_mode;
      fast_sel  <= next_fast_sel;
      div_low   <= next_div_low;
      div_high  <= next_div_high;
      pending   <= next_pending;
      rdata     <= next_rdata;
    end
  end

  assign rdata_out           = rdata;
  assign receive_pending_out = pending;

  // rate: counts timer wraps up to the multiplier
  always_comb begin
    logic [6:0] m;
    m = rate_mult(sync_mode, wide_sel, fast_sel);
    next_mult_cnt = mult_cnt;
    next_bit_tick = 1'b0;
    if (div_write) begin
      next_mult_cnt = 6'h00;
    end else if (timer_wrap) begin
      if ({1'b0, mult_cnt} >= m - 7'h01) begin
        next_mult_cnt = 6'h00;
        next_bit_tick = 1'b1;
      end else begin
        next_mult_cnt = mult_cnt + 6'h01;
      end
    end
    // sync pin carries the bit clock, idle level set by polarity
    if (sync_mode) begin
      next_pin = mult_cnt[1] ^ polarity;
    end else begin
      next_pin = tx_data_in ^ polarity;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mult_cnt     <= 6'h00;
      bit_tick_out <= 1'b0;
      pin          <= 1'b1;
    end else begin
      mult_cnt     <= next_mult_cnt;
      bit_tick_out <= next_bit_tick;
      pin          <= next_pin;
    end
  end

  assign tx_pin_out = pin;

  // line watcher; level moves only once two late stages agree
  always_comb begin
    next_rx_level = (rx_s2 == rx_s3) ? rx_s3 : rx_level;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_level <= 1'b1;
      rx_prev  <= 1'b1;
    end else begin
      rx_s1    <= rx_pin_in;
      rx_s2    <= rx_s1;
      rx_s3    <= rx_s2;
      rx_level <= next_rx_level;
      rx_prev  <= rx_level;
    end
  end

  assign fall = rx_prev && !rx_level;
  assign rise = !rx_prev && rx_level;

  // frame length is counted on free running ticks, so it may end a
  // fraction of a bit early; the idle flag is a guide, not a framer
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    wake_done    = 1'b0;
    case (state)
      st_idle: begin
        if (wake_en && !sync_mode) begin
          next_state = st_wake_fall;
        end else if (fall && !sync_mode) begin
          next_state   = st_busy;
          next_bit_cnt = 4'h0;
        end
      end
      st_busy: begin
        if (sync_mode) begin
          next_state = st_idle;
        end else if (bit_tick_out) begin
          if (bit_cnt == LAST_BIT) begin
            next_state = st_idle;
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
          end
        end
      end
      st_wake_fall: begin
        if (!wake_en || sync_mode) begin
          next_state = st_idle;
        end else if (fall) begin
          next_state = st_wake_rise;
        end
      end
      st_wake_rise: begin
        if (!wake_en || sync_mode) begin
          next_state = st_idle;
        end else if (rise) begin
          next_state = st_idle;
          wake_done  = 1'b1;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state   <= st_idle;
      bit_cnt <= 4'h0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
    end
  end
endmodule
`default_nettype wire

/* File: dv/baud_sva.sv */
// assertions on the baud generator ports
// assumes a bind onto baud_rate_generator, one clock domain
`timescale 1ns/1ps
`default_nettype none
module baud_sva #(
  parameter int FRAME_BITS = 10
) (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       write_in,
  input wire logic       read_in,
  input wire logic [7:0] rdata_out,
  input wire logic       tx_data_in,
  input wire logic       rx_pin_in,
  input wire logic       tx_pin_out,
  input wire logic       bit_tick_out,
  input wire logic       receive_pending_out
);
  logic       pol, wide, fast, sync, armed, clean;
  logic [7:0] lo, hi;
  int         cnt, per;
  always_comb per = (sync ? 4 : wide ? (fast ? 4 : 16) : (fast ? 16 : 64))
                    * ((wide ? int'({hi, lo}) : int'(lo)) + 1);
  // shadow of the control bits, seen through bus writes; armed also drops once pending is seen
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      {pol, wide, fast, sync, armed, clean, lo, hi} <= '0;
      cnt <= 0;
    end else begin
      cnt <= bit_tick_out ? 1 : cnt + 1;
      // a config write spoils the gap until the next tick
      clean <= (bit_tick_out | clean) & !(write_in & addr_in < 8'h04);
      if (receive_pending_out) armed <= 1'b0;
      if (write_in) begin
        case (addr_in)
          8'h00: {pol, wide, armed} <= {wdata_in[4:3], wdata_in[1]};
          8'h01: lo <= wdata_in;
          8'h02: hi <= wdata_in;
          8'h03: {sync, fast} <= {wdata_in[4], wdata_in[2]};
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_tick_pulse;
    bit_tick_out |=> !bit_tick_out;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("bit tick wider than one cycle");
  property p_ctrl_read;
    read_in && addr_in == 8'h00 |=>
      !rdata_out[7] && rdata_out[3] == wide && rdata_out[4] == pol;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read back wrong");
  property p_rd_zero;
    !read_in |=> rdata_out == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data outside its cycle");
  property p_period;
    bit_tick_out && clean |-> cnt == per;
  endproperty
  a_period: assert property (p_period)
    else $error("bit period wrong");
  property p_div_clear;
    write_in && (addr_in == 8'h01 || addr_in == 8'h02) |=> !bit_tick_out [*3];
  endproperty
  a_div_clear: assert property (p_div_clear)
    else $error("tick too soon after divisor write");
  property p_pol;
    !$past(reset_in) && !$past(sync) |->
      tx_pin_out == ($past(tx_data_in) ^ $past(pol));
  endproperty
  a_pol: assert property (p_pol)
    else $error("transmit pin polarity wrong");
  property p_wake_armed;
    $rose(receive_pending_out) |-> armed;
  endproperty
  a_wake_armed: assert property (p_wake_armed)
    else $error("pending set without wake enable");
  property p_pend_clear;
    write_in && addr_in == 8'h04 && wdata_in[0] && !armed
      |=> !receive_pending_out;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("pending not cleared");
  c_wake: cover property ($rose(receive_pending_out));
  c_sync: cover property (bit_tick_out && clean && sync);
  c_wide: cover property (bit_tick_out && clean && wide && !sync);
endmodule
bind baud_rate_generator baud_sva #(.FRAME_BITS(FRAME_BITS)) sva_u (
  .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
  .rdata_out(rdata_out), .tx_data_in(tx_data_in), .rx_pin_in(rx_pin_in),
  .tx_pin_out(tx_pin_out), .bit_tick_out(bit_tick_out),
  .receive_pending_out(receive_pending_out));
`default_nettype wire

/* File: dv/line_peer.sv */
// remote serial transmitter driving the receive line
// assumes its tasks are called just after a rising clk_in edge
`timescale 1ns/1ps
`default_nettype none
module line_peer (
  input  wire logic clk_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // start bit, data lsb first, stop bit; cyc clocks per bit
  task automatic send_byte(input logic [7:0] data, input int cyc);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= frame[i];
      repeat (cyc) @(posedge clk_in);
    end
  endtask
  // bare low pulse: the edge pair that ends a wake wait
  task automatic pulse_low(input int cyc);
    line_out <= 1'b0;
    repeat (cyc) @(posedge clk_in);
    line_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the baud rate generator
// assumes the bound checker and line_peer are compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk_in, reset_in, write_in, read_in, tx_data_in, pol;
  logic       tx_pin_out, bit_tick_out, receive_pending_out, rx_line;
  logic [7:0] addr_in, wdata_in, rdata_out, lo, hi;
  logic [2:0] cfg;
  int         bad_count, check_count, cycles, g, want;
  baud_rate_generator #(.FRAME_BITS(4)) dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
    .rdata_out(rdata_out), .tx_data_in(tx_data_in), .rx_pin_in(rx_line),
    .tx_pin_out(tx_pin_out), .bit_tick_out(bit_tick_out),
    .receive_pending_out(receive_pending_out));
  line_peer peer_u (.clk_in(clk_in), .line_out(rx_line));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      bad_count++;
      results();
    end
  end
  task automatic check(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    {write_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge clk_in);
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    {read_in, addr_in} <= {1'b1, a};
    @(posedge clk_in);
    read_in <= 1'b0;
    #1;
    check(rdata_out, exp);
    @(posedge clk_in);
  endtask
  task automatic tick_gap(output int gap);
    gap = 0;
    do begin
      @(posedge clk_in);
      #1;
      gap++;
    end while (bit_tick_out !== 1'b1 && gap < 40000);
  endtask
  function automatic int period(input logic s, w, f, input int n);
    return (s ? 4 : w ? (f ? 4 : 16) : (f ? 16 : 64)) * (n + 1);
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {reset_in, write_in, read_in, addr_in, wdata_in, tx_data_in} <= 20'h80001;
    void'($urandom(47597));
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    wr(8'h07, 8'hff);
    for (int a = 0; a < 8; a++) rd(a[7:0], a == 0 ? 8'h40 : 8'h00);
    // every stored control bit, unused bits read back as zero
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h5b);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h14);
    // every sync, wide and fast combination, random divisor
    for (int i = 0; i < 8; i++) begin
      cfg = i[2:0];
      lo = 8'($urandom_range(7, 0));
      hi = 8'($urandom_range(1, 0));
      wr(8'h03, {3'h0, cfg[2], 1'b0, cfg[0], 2'h0});
      wr(8'h00, {4'h0, cfg[1], 3'h0});
      wr(8'h01, lo);
      wr(8'h02, hi);
      rd(8'h00, {4'h4, cfg[1], 3'h0});
      tick_gap(g);
      tick_gap(g);
      tick_gap(g);
      want = period(cfg[2], cfg[1], cfg[0], {cfg[1] ? hi : 8'h0, lo});
      check(g, want);
      @(posedge clk_in);
    end
    wr(8'h03, 8'h00);
    for (int i = 0; i < 16; i++) begin
      pol = i[3];
      if (i % 8 == 0) wr(8'h00, {3'h0, pol, 4'h0});
      tx_data_in <= 1'($urandom);
      @(posedge clk_in);
      #1;
      check(tx_pin_out, tx_data_in ^ pol);
      @(posedge clk_in);
    end
    wr(8'h03, 8'h04);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    fork
      peer_u.send_byte(8'hff, 16);
      begin
        repeat (8) @(posedge clk_in);
        rd(8'h00, 8'h00);
      end
    join
    repeat (100) @(posedge clk_in);
    rd(8'h00, 8'h40);
    wr(8'h00, 8'h02);
    peer_u.pulse_low(20);
    repeat (10) @(posedge clk_in);
    rd(8'h00, 8'h40);
    check(receive_pending_out, 32'h1);
    wr(8'h04, 8'h01);
    check(receive_pending_out, 32'h0);
    peer_u.pulse_low(20);
    repeat (10) @(posedge clk_in);
    check(receive_pending_out, 32'h0);
    results();
  end
endmodule
`default_nettype wire
